// ---- design/ddr_out_cell.v ----
`timescale 1ns/100ps
`include "lvds_bypass_defines.vh"

module ddr_out_cell (
   // clock and reset
   input  wire clk_i,
   input  wire reset_i,
   // phase select and data
   input  wire lo_phase_i,
   input  wire data_hi_i,
   input  wire data_lo_i,
   // pin side
   output wire q_o
);

   reg q_r;

   // one cell period is two clk_i cycles: high half then low half
   always @(posedge clk_i) begin
      if (reset_i) begin
         q_r <= 1'h0;
      end else if (lo_phase_i) begin
         q_r <= data_lo_i;
      end else begin
         q_r <= data_hi_i;
      end
   end

   assign q_o = q_r;

endmodule

// ---- design/gearbox_ram.v ----
`timescale 1ns/100ps
`include "lvds_bypass_defines.vh"

module gearbox_ram #(
   parameter WIDE_WRITE = 1
) (
   // clock
   input  wire                      clk_i,
   // enables
   input  wire                      wr_en_i,
   input  wire                      rd_en_i,
   // wide port
   input  wire [`WIDE_ADDR_W-1:0]   wide_addr_i,
   input  wire [`WORD_BITS-1:0]     wide_wdata_i,
   output wire [`WORD_BITS-1:0]     wide_rdata_o,
   // narrow port
   input  wire [`NARROW_ADDR_W-1:0] narrow_addr_i,
   input  wire [`PAIR_BITS-1:0]     narrow_wdata_i,
   output wire [`PAIR_BITS-1:0]     narrow_rdata_o
);

   reg  [`PAIR_BITS-1:0] mem [0:`RAM_DEPTH-1];
   reg  [`WORD_BITS-1:0] wide_rdata_r;
   reg  [`PAIR_BITS-1:0] narrow_rdata_r;
   wire [`WORD_BITS-1:0] wide_word;
   integer               i;

   // wide word a holds narrow entries 4a..4a+3, lowest pair first on the wire
   genvar g;
   generate
      for (g = 0; g < `PAIRS_PER_WORD; g = g + 1) begin : rd_lane
         assign wide_word[g*`PAIR_BITS +: `PAIR_BITS] =
            mem[wide_addr_i * `PAIRS_PER_WORD + g];
      end
   endgenerate

   always @(posedge clk_i) begin
      if (wr_en_i) begin
         if (WIDE_WRITE != 0) begin
            for (i = 0; i < `PAIRS_PER_WORD; i = i + 1) begin
               mem[wide_addr_i * `PAIRS_PER_WORD + i] <= wide_wdata_i[i*`PAIR_BITS +: `PAIR_BITS];
            end
         end else begin
            mem[narrow_addr_i] <= narrow_wdata_i;
         end
      end
      if (rd_en_i) begin
         wide_rdata_r   <= wide_word;
         narrow_rdata_r <= mem[narrow_addr_i];
      end
   end

   assign wide_rdata_o   = wide_rdata_r;
   assign narrow_rdata_o = narrow_rdata_r;

endmodule

// ---- design/lvds_bypass_defines.vh ----
`ifndef LVDS_BYPASS_DEFINES_VH
`define LVDS_BYPASS_DEFINES_VH

// link modes
`define MODE_W           2
`define MODE_X1          2'h0
`define MODE_X2          2'h1
`define MODE_GEARBOX     2'h2
`define MODE_SHIFT       2'h3

// word and pair layout
`define WORD_BITS        8
`define PAIR_BITS        2
`define PAIRS_PER_WORD   4
`define PAIR_CNT_W       2
`define PAIR_CNT_FIRST   2'h0
`define PAIR_CNT_LAST    2'h3
`define PAIR_CNT_INC     2'h1
`define PAIR_ZERO        2'h0
`define WORD_PAD_X1      7
`define WORD_PAD_X2      6

// gearbox counters and memory shape (two-wide by eight-wide)
`define FAST_CNT_W       5
`define SLOW_CNT_W       3
`define FAST_CNT_START   5'h00
`define SLOW_CNT_START   3'h2
`define FAST_CNT_INC     5'h01
`define SLOW_CNT_INC     3'h1
`define NARROW_ADDR_W    8
`define WIDE_ADDR_W      6
`define NARROW_GND       3'h0
`define WIDE_GND         3'h0
`define RAM_DEPTH        256

// initial invalid cycles
`define SEEN_W           5
`define SEEN_ZERO        5'h00
`define SEEN_INC         5'h01
`define TX_WR_INVALID    5'h02
`define TX_RD_INVALID    5'h08
`define RX_WR_INVALID    5'h18
`define RX_RD_INVALID    5'h06

// rates
`define CLK_FREQ_MHZ     50
`define FABRIC_MAX_MBPS  624
`define X2_MAX_MBPS      624
`define DDR_ADVISE_MBPS  231
`define X1_CLK_MAX_MHZ   420
`define CELL_DIV         2

`endif

// ---- design/lvds_fabric_serdes_bypass.v ----
`timescale 1ns/100ps
`include "lvds_bypass_defines.vh"

// Notes on behaviour
// - fabric path only below 624 Mbps serial rate; flagged otherwise
// - x1 and x2 modes always run through this fabric path
// - forwarded clock is a ddr output cell with high input one, low input zero
// - forwarded clock toggles at the ddr cell clock frequency
// - x1 mode: ddr cells advised above 231 Mbps, not mandatory
// - x1 mode output clock must stay at or below 420 MHz
// - x2 mode moves two bits per cell period through ddr cells
// - x2 mode serial rate must not exceed 624 Mbps
// - gearbox fast counter starts at zero, slow counter starts at two
// - gearbox memory is simple dual port, read and write enables held high
// - transmit gearbox reads at fast counter, writes at slow counter
// - receive gearbox writes at fast counter, reads at slow counter
// - receive: fast 5 bits, slow 3; 24 writes and 6 reads invalid
// - transmit: fast 5 bits, slow 3; 2 writes and 8 reads invalid
// - address bits above counter width are tied to zero
// - shift receiver adds a word register that catches each full word
// - shift transmitter counter selects load once per word, shift otherwise
// - optional input register stage, one flop per word bit
// - word width is one of 4, 7, 8 or 10 bits
module lvds_fabric_serdes_bypass (
   // clock and reset
   input  wire                  clk_i,
   input  wire                  reset_i,
   // configuration, hold steady or change only under reset
   input  wire [`MODE_W-1:0]    mode_i,
   input  wire                  tx_reg_en_i,
   // transmit word side
   input  wire [`WORD_BITS-1:0] tx_data_i,
   output wire                  tx_ready_o,
   output wire                  tx_out_valid_o,
   // transmit pins
   output wire                  tx_ser_o,
   output wire                  tx_clk_o,
   // receive pins
   input  wire                  rx_ser_i,
   input  wire                  rx_clk_i,
   // receive word side
   output wire [`WORD_BITS-1:0] rx_data_o,
   output wire                  rx_valid_o,
   // link checks
   output wire                  rate_ok_o,
   output wire                  ddr_advised_o
);

   // rates seen by this build: one cell period is two clk_i cycles
   localparam integer CELL_MHZ    = `CLK_FREQ_MHZ / `CELL_DIV;
   localparam integer X1_MBPS     = CELL_MHZ;
   localparam integer X2_MBPS     = CELL_MHZ * `PAIR_BITS;
   localparam integer WORD_OK     = (`WORD_BITS == 4) || (`WORD_BITS == 7) ||
                                    (`WORD_BITS == 8) || (`WORD_BITS == 10);
   localparam integer X1_OK       = (X1_MBPS < `FABRIC_MAX_MBPS) &&
                                    (CELL_MHZ <= `X1_CLK_MAX_MHZ);
   localparam integer X2_OK       = (X2_MBPS <= `X2_MAX_MBPS) &&
                                    (X2_MBPS < `FABRIC_MAX_MBPS);
   localparam integer WIDE_OK     = (X2_MBPS < `FABRIC_MAX_MBPS);
   localparam integer X1_ADVISE   = (X1_MBPS > `DDR_ADVISE_MBPS);

   // saturating count of gearbox accesses
   function [`SEEN_W-1:0] sat_inc;
      input [`SEEN_W-1:0] cnt;
      input [`SEEN_W-1:0] lim;
      begin
         if (cnt < lim) begin
            sat_inc = cnt + `SEEN_INC;
         end else begin
            sat_inc = cnt;
         end
      end
   endfunction

   // cell phase, shared by every ddr output cell
   reg                      phase_r;
   wire                     cell_end;

   // transmit state
   reg  [`WORD_BITS-1:0]    tx_stage_r;
   wire [`WORD_BITS-1:0]    tx_word;
   reg  [`PAIR_CNT_W-1:0]   tx_pcnt_r;
   wire [`PAIR_CNT_W-1:0]   tx_pcnt_nxt;
   reg  [`WORD_BITS-1:0]    tx_sh_r;
   reg                      tx_hi_r;
   reg                      tx_lo_r;
   reg  [`FAST_CNT_W-1:0]   tx_fast_r;
   reg  [`SLOW_CNT_W-1:0]   tx_slow_r;
   reg  [`SEEN_W-1:0]       tx_wr_seen_r;
   reg  [`SEEN_W-1:0]       tx_rd_seen_r;
   reg                      tx_valid_r;
   wire                     tx_direct;
   wire                     tx_take;
   wire [`PAIR_BITS-1:0]    tx_ram_pair;

   // receive state
   reg                      rck_s1_r;
   reg                      rck_s2_r;
   reg                      rck_s3_r;
   reg                      rdat_s1_r;
   reg                      rdat_s2_r;
   wire                     rx_rise;
   wire                     rx_fall;
   reg                      rx_hi_r;
   wire [`PAIR_BITS-1:0]    rx_pair;
   reg  [`PAIR_CNT_W-1:0]   rx_pcnt_r;
   reg  [`WORD_BITS-1:0]    rx_sh_r;
   reg  [`WORD_BITS-1:0]    rx_data_r;
   reg                      rx_valid_r;
   reg  [`FAST_CNT_W-1:0]   rx_fast_r;
   reg  [`SLOW_CNT_W-1:0]   rx_slow_r;
   reg  [`SEEN_W-1:0]       rx_wr_seen_r;
   reg  [`SEEN_W-1:0]       rx_rd_seen_r;
   wire [`WORD_BITS-1:0]    rx_ram_word;

   // link checks
   reg                      rate_ok_r;
   reg                      ddr_advised_r;

   assign cell_end    = phase_r;
   assign tx_pcnt_nxt = tx_pcnt_r + `PAIR_CNT_INC;
   assign tx_direct   = (mode_i == `MODE_X1) || (mode_i == `MODE_X2);

   // the staged word lags tx_data_i by one cycle; it cuts the core-to-link timing path
   assign tx_word     = tx_reg_en_i ? tx_stage_r : tx_data_i;
   assign tx_take     = cell_end && (tx_direct || (tx_pcnt_r == `PAIR_CNT_FIRST));
   assign tx_ready_o  = tx_take;

   always @(posedge clk_i) begin
      if (reset_i) begin
         phase_r      <= 1'h0;
         tx_stage_r   <= {`WORD_BITS{1'h0}};
         tx_pcnt_r    <= `PAIR_CNT_FIRST;
         tx_sh_r      <= {`WORD_BITS{1'h0}};
         tx_hi_r      <= 1'h0;
         tx_lo_r      <= 1'h0;
         tx_fast_r    <= `FAST_CNT_START;
         tx_slow_r    <= `SLOW_CNT_START;
         tx_wr_seen_r <= `SEEN_ZERO;
         tx_rd_seen_r <= `SEEN_ZERO;
         tx_valid_r   <= 1'h0;
      end else begin
         phase_r    <= ~phase_r;
         tx_stage_r <= tx_data_i;
         if (cell_end) begin
            tx_pcnt_r <= tx_pcnt_nxt;
            case (mode_i)
               `MODE_X1: begin
                  // single rate: the same bit on both halves
                  tx_hi_r    <= tx_word[0];
                  tx_lo_r    <= tx_word[0];
                  tx_valid_r <= 1'h1;
               end
               `MODE_X2: begin
                  tx_hi_r    <= tx_word[0];
                  tx_lo_r    <= tx_word[1];
                  tx_valid_r <= 1'h1;
               end
               `MODE_SHIFT: begin
                  if (tx_take) begin
                     // parallel load, first pair straight to the cell
                     tx_hi_r    <= tx_word[0];
                     tx_lo_r    <= tx_word[1];
                     tx_sh_r    <= {`PAIR_ZERO, tx_word[`WORD_BITS-1:`PAIR_BITS]};
                     tx_valid_r <= 1'h1;
                  end else begin
                     tx_hi_r <= tx_sh_r[0];
                     tx_lo_r <= tx_sh_r[1];
                     tx_sh_r <= {`PAIR_ZERO, tx_sh_r[`WORD_BITS-1:`PAIR_BITS]};
                  end
               end
               default: begin
                  tx_hi_r      <= tx_ram_pair[0];
                  tx_lo_r      <= tx_ram_pair[1];
                  tx_fast_r    <= tx_fast_r + `FAST_CNT_INC;
                  tx_rd_seen_r <= sat_inc(tx_rd_seen_r, `TX_RD_INVALID);
                  if (tx_take) begin
                     tx_slow_r    <= tx_slow_r + `SLOW_CNT_INC;
                     tx_wr_seen_r <= sat_inc(tx_wr_seen_r, `TX_WR_INVALID);
                  end
                  // counts are the old ones: the pair now loaded is the first valid one
                  tx_valid_r <= (tx_wr_seen_r >= `TX_WR_INVALID) &&
                                (tx_rd_seen_r >= `TX_RD_INVALID);
               end
            endcase
         end
      end
   end

   // transmit gearbox: the memory writes every cycle, so the word present when the
   // slow counter moves is the one that stays behind in that slot
   gearbox_ram #(
      .WIDE_WRITE (1)
   ) tx_ram (
      .clk_i          (clk_i),
      .wr_en_i        (1'h1),
      .rd_en_i        (1'h1),
      .wide_addr_i    ({`WIDE_GND, tx_slow_r}),
      .wide_wdata_i   (tx_word),
      .wide_rdata_o   (),
      .narrow_addr_i  ({`NARROW_GND, tx_fast_r}),
      .narrow_wdata_i (`PAIR_ZERO),
      .narrow_rdata_o (tx_ram_pair)
   );

   ddr_out_cell tx_data_cell (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .lo_phase_i (phase_r),
      .data_hi_i  (tx_hi_r),
      .data_lo_i  (tx_lo_r),
      .q_o        (tx_ser_o)
   );

   // forwarded clock: same cell, fixed one and zero, so it runs at the cell rate
   ddr_out_cell tx_clk_cell (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .lo_phase_i (phase_r),
      .data_hi_i  (1'h1),
      .data_lo_i  (1'h0),
      .q_o        (tx_clk_o)
   );

   assign tx_out_valid_o = tx_valid_r;

   // receive pins pass two flops; the remote clock must stay well below clk_i/4
   assign rx_rise = rck_s2_r & ~rck_s3_r;
   assign rx_fall = ~rck_s2_r & rck_s3_r;
   // gearbox pair: high bit as it stands now, low bit caught at the last rise
   assign rx_pair = {rdat_s2_r, rx_hi_r};

   always @(posedge clk_i) begin
      if (reset_i) begin
         rck_s1_r  <= 1'h0;
         rck_s2_r  <= 1'h0;
         rck_s3_r  <= 1'h0;
         rdat_s1_r <= 1'h0;
         rdat_s2_r <= 1'h0;
      end else begin
         rck_s1_r  <= rx_clk_i;
         rck_s2_r  <= rck_s1_r;
         rck_s3_r  <= rck_s2_r;
         rdat_s1_r <= rx_ser_i;
         rdat_s2_r <= rdat_s1_r;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         rx_hi_r      <= 1'h0;
         rx_pcnt_r    <= `PAIR_CNT_FIRST;
         rx_sh_r      <= {`WORD_BITS{1'h0}};
         rx_data_r    <= {`WORD_BITS{1'h0}};
         rx_valid_r   <= 1'h0;
         rx_fast_r    <= `FAST_CNT_START;
         rx_slow_r    <= `SLOW_CNT_START;
         rx_wr_seen_r <= `SEEN_ZERO;
         rx_rd_seen_r <= `SEEN_ZERO;
      end else begin
         rx_valid_r <= 1'h0;
         if (rx_rise) begin
            rx_hi_r <= rdat_s2_r;
         end
         case (mode_i)
            `MODE_X1: begin
               if (rx_rise) begin
                  rx_data_r  <= {{`WORD_PAD_X1{1'h0}}, rdat_s2_r};
                  rx_valid_r <= 1'h1;
               end
            end
            `MODE_X2: begin
               if (rx_fall) begin
                  rx_data_r  <= {{`WORD_PAD_X2{1'h0}}, rdat_s2_r, rx_hi_r};
                  rx_valid_r <= 1'h1;
               end
            end
            `MODE_SHIFT: begin
               if (rx_fall) begin
                  rx_sh_r   <= {rdat_s2_r, rx_hi_r, rx_sh_r[`WORD_BITS-1:`PAIR_BITS]};
                  rx_pcnt_r <= rx_pcnt_r + `PAIR_CNT_INC;
                  if (rx_pcnt_r == `PAIR_CNT_LAST) begin
                     rx_data_r  <= {rdat_s2_r, rx_hi_r,
                                    rx_sh_r[`WORD_BITS-1:`PAIR_BITS]};
                     rx_valid_r <= 1'h1;
                  end
               end
            end
            default: begin
               // the memory writes every cycle; the pair standing when the fall moves
               // the fast counter stays behind, so pair n lands at address n
               if (rx_fall) begin
                  rx_fast_r    <= rx_fast_r + `FAST_CNT_INC;
                  rx_wr_seen_r <= sat_inc(rx_wr_seen_r, `RX_WR_INVALID);
                  if (rx_fast_r[`PAIR_CNT_W-1:0] == `PAIR_CNT_LAST) begin
                     rx_data_r    <= rx_ram_word;
                     rx_slow_r    <= rx_slow_r + `SLOW_CNT_INC;
                     rx_rd_seen_r <= sat_inc(rx_rd_seen_r, `RX_RD_INVALID);
                     rx_valid_r   <= (rx_wr_seen_r >= `RX_WR_INVALID) &&
                                     (rx_rd_seen_r >= `RX_RD_INVALID);
                  end
               end
            end
         endcase
      end
   end

   gearbox_ram #(
      .WIDE_WRITE (0)
   ) rx_ram (
      .clk_i          (clk_i),
      .wr_en_i        (1'h1),
      .rd_en_i        (1'h1),
      .wide_addr_i    ({`WIDE_GND, rx_slow_r}),
      .wide_wdata_i   ({`WORD_BITS{1'h0}}),
      .wide_rdata_o   (rx_ram_word),
      .narrow_addr_i  ({`NARROW_GND, rx_fast_r}),
      .narrow_wdata_i (rx_pair),
      .narrow_rdata_o ()
   );

   assign rx_data_o  = rx_data_r;
   assign rx_valid_o = rx_valid_r;

   // static rate checks per mode; no dedicated serializer exists, so a failing
   // rate is only reported, never rerouted
   always @(posedge clk_i) begin
      if (reset_i) begin
         rate_ok_r     <= 1'h0;
         ddr_advised_r <= 1'h0;
      end else begin
         case (mode_i)
            `MODE_X1: begin
               rate_ok_r     <= (WORD_OK != 0) && (X1_OK != 0);
               ddr_advised_r <= (X1_ADVISE != 0);
            end
            `MODE_X2: begin
               rate_ok_r     <= (WORD_OK != 0) && (X2_OK != 0);
               ddr_advised_r <= 1'h0;
            end
            default: begin
               rate_ok_r     <= (WORD_OK != 0) && (WIDE_OK != 0);
               ddr_advised_r <= 1'h0;
            end
         endcase
      end
   end

   assign rate_ok_o     = rate_ok_r;
   assign ddr_advised_o = ddr_advised_r;

endmodule

// ---- tb/lvds_bypass_assertions.sv ----
`timescale 1ns/100ps
`include "lvds_bypass_defines.vh"
module lvds_bypass_assertions (
   // clock and reset
   input wire                  clk_i,
   input wire                  reset_i,
   // configuration and transmit words
   input wire [`MODE_W-1:0]    mode_i,
   input wire                  tx_reg_en_i,
   input wire [`WORD_BITS-1:0] tx_data_i,
   input wire                  tx_ready_o,
   input wire                  tx_out_valid_o,
   // pins
   input wire                  tx_ser_o,
   input wire                  tx_clk_o,
   input wire                  rx_ser_i,
   input wire                  rx_clk_i,
   // receive words and link checks
   input wire [`WORD_BITS-1:0] rx_data_o,
   input wire                  rx_valid_o,
   input wire                  rate_ok_o,
   input wire                  ddr_advised_o
);
   reg  [8:0] run_r;
   wire       gear = (mode_i == `MODE_GEARBOX);
   wire       blk  = (mode_i == `MODE_GEARBOX) || (mode_i == `MODE_SHIFT);
   // saturates so a long run never wraps into the start-up window
   always @(posedge clk_i) begin
      if (reset_i) begin
         run_r <= 9'h000;
      end else if (run_r != 9'h1FF) begin
         run_r <= run_r + 9'h001;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_pair_gap;
      !tx_ready_o ##1 tx_ready_o;
   endsequence
   sequence s_word_gap;
      !tx_ready_o [*7] ##1 tx_ready_o;
   endsequence
   a_pair_cadence: assert property (tx_ready_o && !blk |=> s_pair_gap)
      else $error("take not every second cycle");
   a_word_cadence: assert property (tx_ready_o && blk |=> s_word_gap)
      else $error("take not once per word");
   a_fwd_clk_toggle: assert property (tx_out_valid_o && $past(tx_out_valid_o) |->
      tx_clk_o != $past(tx_clk_o)) else $error("forwarded clock not toggling");
   a_x1_bit_hold: assert property ((mode_i == `MODE_X1) && tx_out_valid_o && tx_clk_o
      |=> tx_ser_o == $past(tx_ser_o)) else $error("x1 bit not held a cell");
   a_rate_flags: assert property (!$past(reset_i) && !$past(reset_i, 2)
      |-> rate_ok_o && !ddr_advised_o) else $error("rate flags wrong");
   a_release_quiet: assert property ($past(reset_i) |->
      !tx_ready_o && !tx_out_valid_o && !rx_valid_o && !tx_clk_o) else $error("busy at release");
   a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("receive valid longer than a cycle");
   a_rx_x2_narrow: assert property (rx_valid_o && (mode_i == `MODE_X2)
      |-> rx_data_o[7:2] == 6'h00) else $error("x2 upper bits set");
   a_rx_x1_narrow: assert property (rx_valid_o && (mode_i == `MODE_X1)
      |-> rx_data_o[7:1] == 7'h00) else $error("x1 upper bits set");
   a_rx_gear_wait: assert property (rx_valid_o && gear |-> run_r >= 9'h0B4)
      else $error("gearbox word before write fill");
   a_tx_gear_wait: assert property ($rose(tx_out_valid_o) && gear |-> run_r >= 9'h010)
      else $error("gearbox output valid too early");
endmodule

bind lvds_fabric_serdes_bypass lvds_bypass_assertions lvds_bypass_assertions_i (
   .clk_i(clk_i), .reset_i(reset_i), .mode_i(mode_i), .tx_reg_en_i(tx_reg_en_i),
   .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .tx_out_valid_o(tx_out_valid_o),
   .tx_ser_o(tx_ser_o), .tx_clk_o(tx_clk_o), .rx_ser_i(rx_ser_i), .rx_clk_i(rx_clk_i),
   .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rate_ok_o(rate_ok_o),
   .ddr_advised_o(ddr_advised_o));

// ---- tb/lvds_fabric_serdes_bypass_tb.sv ----
`timescale 1ns/100ps
`include "lvds_bypass_defines.vh"
module lvds_fabric_serdes_bypass_tb;
   reg                  clk_i;
   reg                  reset_i;
   reg [`MODE_W-1:0]    mode_i;
   reg                  tx_reg_en_i;
   reg [`WORD_BITS-1:0] tx_data_i;
   wire                 tx_ready_o, tx_out_valid_o, tx_ser_o, tx_clk_o, rx_ser_i, rx_clk_i;
   wire [7:0]           rx_data_o;
   wire                 rx_valid_o, rate_ok_o, ddr_advised_o;
   integer              error_cnt;
   integer              tests_run;
   reg                  mon_on, rx_on;
   logic                tx_q[$];
   logic                clk_q[$];
   logic [7:0]          rx_q[$];

   lvds_fabric_serdes_bypass lvds_fabric_serdes_bypass_i (
      .clk_i(clk_i), .reset_i(reset_i), .mode_i(mode_i), .tx_reg_en_i(tx_reg_en_i),
      .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .tx_out_valid_o(tx_out_valid_o),
      .tx_ser_o(tx_ser_o), .tx_clk_o(tx_clk_o), .rx_ser_i(rx_ser_i), .rx_clk_i(rx_clk_i),
      .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rate_ok_o(rate_ok_o),
      .ddr_advised_o(ddr_advised_o));
   remote_link_model remote_link_model_i (.ser_o(rx_ser_i), .fwd_clk_o(rx_clk_i));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // outputs are read at the falling edge, where they are settled
   always @(negedge clk_i) begin
      if (mon_on && tx_out_valid_o === 1'b1) begin
         tx_q.push_back(tx_ser_o);
         clk_q.push_back(tx_clk_o);
      end
      if (rx_on && rx_valid_o === 1'b1) begin
         rx_q.push_back(rx_data_o);
      end
   end

   function [7:0] wrd(input [7:0] base, input [7:0] step, input integer k);
      wrd = base + step * k[7:0];
   endfunction
   task chk_b(input logic act, input logic exp, input string msg);
      begin
         tests_run = tests_run + 1;
         if (act !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: %s got %b exp %b", $time, msg, act, exp);
         end
      end
   endtask
   task chk_w(input logic [7:0] act, input logic [7:0] exp, input string msg);
      begin
         tests_run = tests_run + 1;
         if (act !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, act, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask
   task do_reset(input [1:0] m, input r);
      begin
         @(posedge clk_i);
         reset_i     <= 1'b1;
         mode_i      <= m;
         tx_reg_en_i <= r;
         repeat (7) @(posedge clk_i);
         @(negedge clk_i);
         chk_b(tx_ready_o | tx_out_valid_o | rx_valid_o | tx_clk_o, 1'b0, "quiet");
         @(posedge clk_i);
         reset_i <= 1'b0;
      end
   endtask
   task t_flags;
      integer m;
      begin
         for (m = 0; m < 4; m = m + 1) begin
            do_reset(m[1:0], 1'b0);
            repeat (4) @(negedge clk_i);
            chk_b(rate_ok_o, 1'b1, "rate ok");
            chk_b(ddr_advised_o, 1'b0, "ddr advice");
         end
         $display("test flags done");
      end
   endtask
   // bits per word, repeat of each bit, expected cycles between takes
   task t_tx(input [1:0] m, input r, input integer bits, input integer rep, input integer gap);
      integer n, w, last, b, k0, off, i;
      reg     ok, found;
      reg [7:0] e;
      begin
         do_reset(m, r);
         tx_data_i <= wrd(8'hB4, 8'h3B, 0);
         tx_q.delete();
         clk_q.delete();
         mon_on = 1'b1;
         n = 0;
         w = 0;
         last = 0;
         while (n < 12 && w < 400) begin
            @(negedge clk_i);
            w = w + 1;
            if (tx_ready_o === 1'b1) begin
               if (n > 0) chk_w(w - last, gap, "take spacing");
               last = w;
               n = n + 1;
               @(posedge clk_i);
               tx_data_i <= wrd(8'hB4, 8'h3B, n);
            end
         end
         if (n < 12) begin
            chk_b(1'b0, 1'b1, "take timeout");
            give_verdict;
         end
         repeat (24) @(negedge clk_i);
         mon_on = 1'b0;
         b = bits * rep;
         found = 1'b0;
         for (k0 = 0; k0 < 3; k0 = k0 + 1) begin
            for (off = 0; off < 3 * b + 4; off = off + 1) begin
               ok = 1'b1;
               for (i = 0; i < 6 * b; i = i + 1) begin
                  e = wrd(8'hB4, 8'h3B, k0 + i / b) >> ((i % b) / rep);
                  if (off + i >= tx_q.size() || tx_q[off+i] !== e[0]) ok = 1'b0;
               end
               if (ok && clk_q[off] === 1'b1) found = 1'b1;
            end
         end
         chk_b(found, 1'b1, "serial stream lsb first, high half with clock high");
         $display("test transmit mode %0d done", m);
      end
   endtask
   task t_rx(input [1:0] m, input integer ppw, input [7:0] base, input [7:0] step,
             input [7:0] mask, input integer nw, input integer lo, input integer hi);
      integer n, i;
      begin
         do_reset(m, 1'b0);
         repeat (4) @(posedge clk_i);
         rx_q.delete();
         rx_on = 1'b1;
         remote_link_model_i.send_stream(base, step, nw, ppw);
         repeat (8) @(negedge clk_i);
         rx_on = 1'b0;
         n = rx_q.size();
         chk_b(n >= lo && n <= hi, 1'b1, "receive word count");
         for (i = 0; i < n; i = i + 1) begin
            chk_w(rx_q[i], wrd(base, step, i) & mask, "receive word");
         end
         $display("test receive mode %0d done", m);
      end
   endtask

   initial begin
      reset_i     = 1'b1;
      mode_i      = `MODE_X1;
      tx_reg_en_i = 1'b0;
      tx_data_i   = 8'h00;
      error_cnt   = 0;
      tests_run   = 0;
      mon_on      = 1'b0;
      rx_on       = 1'b0;
      t_flags;
      t_tx(`MODE_X1, 1'b0, 1, 2, 2);
      t_tx(`MODE_X2, 1'b0, 2, 1, 2);
      t_tx(`MODE_SHIFT, 1'b0, 8, 1, 8);
      t_tx(`MODE_SHIFT, 1'b1, 8, 1, 8);
      t_tx(`MODE_GEARBOX, 1'b0, 8, 1, 8);
      t_tx(`MODE_GEARBOX, 1'b1, 8, 1, 8);
      t_rx(`MODE_X1, 1, 8'h1E, 8'h3B, 8'h01, 6, 6, 6);
      t_rx(`MODE_X2, 1, 8'h1E, 8'h3B, 8'h03, 6, 6, 6);
      t_rx(`MODE_SHIFT, 4, 8'hC6, 8'h3B, 8'hFF, 4, 4, 4);
      t_rx(`MODE_GEARBOX, 4, 8'h55, 8'h3B, 8'hFF, 16, 10, 10);
      give_verdict;
   end
endmodule

// ---- tb/remote_link_model.sv ----
`timescale 1ns/100ps
module remote_link_model (
   // remote pins
   output reg ser_o,
   output reg fwd_clk_o
);
   reg [7:0] w;
   integer   k;
   integer   p;
   initial begin
      ser_o     = 1'b0;
      fwd_clk_o = 1'b0;
   end
   // data moves a quarter period away from each clock edge so it is steady when caught
   task send_stream(input [7:0] base, input [7:0] step, input integer nw, input integer ppw);
      begin
         #7;
         for (k = 0; k < nw; k = k + 1) begin
            w = base + step * k[7:0];
            for (p = 0; p < ppw; p = p + 1) begin
               ser_o = w[2*p];
               #40 fwd_clk_o = 1'b1;
               #40 ser_o = w[2*p+1];
               #40 fwd_clk_o = 1'b0;
               #40;
            end
         end
         // clock stands still between frames; data shows the inverse of the last bit
         ser_o = ~ser_o;
      end
   endtask
endmodule
